// >>> frame_source_model.sv
/* Trigger source and sensor path stand-in.
   Assumes the bench requests triggers on shoot. */
`timescale 1ns/10ps
module frame_source_model #(
  parameter int FRAME_LEN = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic shoot,
  input wire logic rude,
  input wire logic waiting_for_trigger,
  input wire logic frame_start,
  output logic frame_trig_pin,
  output logic frame_done
);
  int left;
  // Rude ignores the waiting status, only to probe refusal
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_trig_pin <= 1'b0;
      frame_done <= 1'b0;
      left <= 0;
    end else begin
      frame_trig_pin <= shoot && (waiting_for_trigger || rude);
      frame_done <= (left == 1);
      left <= frame_start ? FRAME_LEN : (left > 0 ? left - 1 : 0);
    end
  end
endmodule

// >>> param_set_sequencer.sv
/*
  Parameter set sequencer, controlled advance with the hardware source off.
  Assumes registers on a plain strobe port and a frame_done pulse from the sensor path.
  The trigger pin is sampled through three flip-flops.
*/
// Summary of operation
// - Step to next higher set only on async_step_cmd.
// - Restart the cycle only on async_rewind_cmd.
// - Switching sequencer_on loads set 0 into the active set.
// - Accepted frame trigger latches the active set as frame parameters.
// - After the last set the next step wraps to set 0.
// - Valid indices run from 0 to set count minus one.
// - Pending step applied while waiting loads the next set.
// - Pending rewind loads set 0 and starts a new cycle.
// - Waiting status is low during every set load.
// - Triggers arriving during a load are ignored.
// - Commands take effect after a variable latency.
// - Switching off mid-frame finishes the frame before stopping.
// - Switching off restores the active set held before switching on.
// - Set count up to 64 is supported.
`timescale 1ns/10ps
`include "seq_map.svh"
module param_set_sequencer #(
  parameter int MAX_SETS = `SEQ_MAX_SETS,
  parameter int LOAD_CYCLES = `SEQ_LOAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`SEQ_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_trig_pin,
  input wire logic frame_done,
  output logic waiting_for_trigger,
  output logic frame_start,
  output logic [`SEQ_PARAM_W-1:0] frame_params,
  output logic [`SEQ_PARAM_W-1:0] active_set,
  output logic [`SEQ_IDX_W-1:0] current_index
);
  seq_load_if lif ();
  seq_load_timer #(.LOAD_CYCLES(LOAD_CYCLES)) u_load (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .lif(lif)
  );

  // Stored sets, written by software one word per set
  seq_pkg::param_t set_mem [MAX_SETS];

  seq_pkg::seq_state_e state_reg;
  seq_pkg::seq_state_e state_next;
  logic sequencer_on;
  logic [`SEQ_IDX_W:0] set_count_reg;
  seq_pkg::idx_t sel_reg;

  seq_pkg::idx_t idx_reg;
  seq_pkg::idx_t idx_next;
  seq_pkg::idx_t load_idx_reg;

  seq_pkg::param_t active_reg;
  seq_pkg::param_t saved_reg;
  seq_pkg::param_t frame_reg;

  logic step_pend_reg;
  logic rewind_pend_reg;

  logic [2:0] trig_sync_reg;
  logic trig_level_reg;
  logic frame_start_reg;
  logic [31:0] rdata_reg;

  function automatic seq_pkg::idx_t next_index(input seq_pkg::idx_t cur,
                                               input logic [`SEQ_IDX_W:0] count);
    logic [`SEQ_IDX_W:0] nxt;
    nxt = {1'b0, cur} + {1'b0, `SEQ_IDX_ONE};
    if (nxt >= count) begin
      next_index = `SEQ_FIRST_SET;
    end else begin
      next_index = nxt[`SEQ_IDX_W-1:0];
    end
  endfunction

  function automatic logic addr_hit(input logic [`SEQ_ADDR_W-1:0] addr,
                                    input logic [`SEQ_ADDR_W-1:0] code);
    addr_hit = (addr == code);
  endfunction

  // Register decode
  wire wr_ctrl = reg_wr && addr_hit(reg_addr, `SEQ_REG_CTRL);
  wire wr_count = reg_wr && addr_hit(reg_addr, `SEQ_REG_COUNT);
  wire wr_sel = reg_wr && addr_hit(reg_addr, `SEQ_REG_SEL);
  wire wr_data = reg_wr && addr_hit(reg_addr, `SEQ_REG_DATA);
  wire wr_active = reg_wr && addr_hit(reg_addr, `SEQ_REG_ACTIVE);
  wire wr_cmd = reg_wr && addr_hit(reg_addr, `SEQ_REG_CMD);
  wire step_bit = reg_wdata[`SEQ_BIT_STEP];
  wire rewind_bit = reg_wdata[`SEQ_BIT_REWIND];
  wire step_cmd = wr_cmd && step_bit;
  wire rewind_cmd = wr_cmd && rewind_bit;

  // Set count changes only while off, so a live cycle never sees a shrinking range
  wire [`SEQ_IDX_W:0] count_word = reg_wdata[`SEQ_IDX_W:0];
  wire count_nonzero = (count_word != '0);
  wire count_in_range = (count_word <= MAX_SETS[`SEQ_IDX_W:0]);
  wire count_ok = count_nonzero && count_in_range;

  // Trigger edge detected only once second and third stages agree
  wire trig_stable = (trig_sync_reg[1] == trig_sync_reg[2]);
  wire trig_rise = trig_stable && trig_sync_reg[2] && !trig_level_reg;

  wire is_wait = (state_reg == seq_pkg::st_wait);
  wire is_idle = (state_reg == seq_pkg::st_idle);
  wire is_drain = (state_reg == seq_pkg::st_drain);
  // Rewind outranks a step pending at the same time
  wire do_rewind = is_wait && rewind_pend_reg;
  wire do_step = is_wait && step_pend_reg && !rewind_pend_reg;
  wire apply_load = do_rewind || do_step;
  wire turn_on = is_idle && sequencer_on;
  // A load about to start hides the waiting status, so no trigger slips in beside it
  wire load_coming = apply_load || turn_on;
  wire accept_trig = trig_rise && (is_wait || is_idle) && !load_coming;

  assign lif.start = load_coming;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      seq_pkg::st_idle: begin
        if (turn_on) begin
          state_next = seq_pkg::st_load;
        end
      end
      seq_pkg::st_load: begin
        if (lif.done) begin
          state_next = seq_pkg::st_wait;
        end
      end
      seq_pkg::st_wait: begin
        if (!sequencer_on) begin
          state_next = seq_pkg::st_drain;
        end else if (apply_load) begin
          state_next = seq_pkg::st_load;
        end else if (accept_trig) begin
          state_next = seq_pkg::st_frame;
        end
      end
      seq_pkg::st_frame: begin
        if (frame_done) begin
          state_next = sequencer_on ? seq_pkg::st_wait : seq_pkg::st_drain;
        end
      end
      seq_pkg::st_drain: begin
        state_next = seq_pkg::st_idle;
      end
    endcase
  end

  always_comb begin
    idx_next = idx_reg;
    if (turn_on) begin
      idx_next = `SEQ_FIRST_SET;
    end else if (do_rewind) begin
      idx_next = `SEQ_FIRST_SET;
    end else if (do_step) begin
      idx_next = next_index(idx_reg, set_count_reg);
    end
  end

  // No reset on the store: software fills every set it means to use
  always_ff @(posedge ref_clk) begin
    if (wr_data) begin
      set_mem[sel_reg] <= reg_wdata[`SEQ_PARAM_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= seq_pkg::st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idx_reg <= `SEQ_FIRST_SET;
    end else begin
      idx_reg <= idx_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      load_idx_reg <= `SEQ_FIRST_SET;
    end else if (lif.start) begin
      load_idx_reg <= idx_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sequencer_on <= 1'b0;
    end else if (wr_ctrl) begin
      sequencer_on <= reg_wdata[`SEQ_BIT_ON];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      set_count_reg <= MAX_SETS[`SEQ_IDX_W:0];
    end else if (wr_count && !sequencer_on && count_ok) begin
      set_count_reg <= count_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sel_reg <= `SEQ_FIRST_SET;
    end else if (wr_sel) begin
      sel_reg <= reg_wdata[`SEQ_IDX_W-1:0];
    end
  end

  // Commands wait here for an unspecified time until the device is waiting
  always_ff @(posedge ref_clk) begin
    if (!rstn || !sequencer_on) begin
      step_pend_reg <= 1'b0;
    end else begin
      step_pend_reg <= step_cmd || (step_pend_reg && !(do_step || do_rewind));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || !sequencer_on) begin
      rewind_pend_reg <= 1'b0;
    end else begin
      rewind_pend_reg <= rewind_cmd || (rewind_pend_reg && !do_rewind);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      saved_reg <= '0;
    end else if (turn_on) begin
      saved_reg <= active_reg;
    end
  end

  // Software may only poke the active set while the sequencer is idle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      active_reg <= '0;
    end else if (is_drain) begin
      active_reg <= saved_reg;
    end else if (lif.done) begin
      active_reg <= set_mem[load_idx_reg];
    end else if (wr_active && is_idle) begin
      active_reg <= reg_wdata[`SEQ_PARAM_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trig_sync_reg <= 3'h0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], frame_trig_pin};
    end
  end

  // Level starts low like the idle pin, so reset never fakes an edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trig_level_reg <= 1'b0;
    end else if (trig_stable) begin
      trig_level_reg <= trig_sync_reg[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_start_reg <= 1'b0;
    end else begin
      frame_start_reg <= accept_trig;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_reg <= '0;
    end else if (accept_trig) begin
      frame_reg <= active_reg;
    end
  end

  always_comb begin
    unique case (reg_addr)
      `SEQ_REG_CTRL: begin
        rdata_reg = {31'h0, sequencer_on};
      end
      `SEQ_REG_COUNT: begin
        rdata_reg = {25'h0, set_count_reg};
      end
      `SEQ_REG_SEL: begin
        rdata_reg = {26'h0, sel_reg};
      end
      `SEQ_REG_DATA: begin
        rdata_reg = set_mem[sel_reg];
      end
      `SEQ_REG_ACTIVE: begin
        rdata_reg = active_reg;
      end
      `SEQ_REG_STATUS: begin
        rdata_reg = {24'h0, rewind_pend_reg, step_pend_reg, idx_reg};
      end
      default: begin
        rdata_reg = 32'h0;
      end
    endcase
  end

  // Read data stand only in the cycle after each cycle of reg_rd and are zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_reg;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Idle counts as waiting: with the sequencer off triggers pass straight through
  assign waiting_for_trigger = (is_wait || is_idle) && !lif.busy && !load_coming;
  assign frame_start = frame_start_reg;
  assign frame_params = frame_reg;
  assign active_set = active_reg;
  assign current_index = idx_reg;
endmodule

// >>> param_set_sequencer_asserts.sv
/* Port checker of the sequencer.
   Assumes one clock and seq_map.svh on the include path. */
`timescale 1ns/10ps
`include "seq_map.svh"
module param_set_sequencer_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic frame_done,
  input wire logic waiting_for_trigger,
  input wire logic frame_start,
  input wire logic [`SEQ_PARAM_W-1:0] frame_params,
  input wire logic [`SEQ_PARAM_W-1:0] active_set,
  input wire logic [`SEQ_IDX_W-1:0] current_index
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_start_pulse: assert property (frame_start |=> !frame_start)
    else $error("start too long");
  a_start_waiting: assert property (frame_start |-> $past(waiting_for_trigger))
    else $error("start while busy");
  a_frame_busy: assert property (frame_start |-> !waiting_for_trigger)
    else $error("waiting in frame");
  a_params_take: assert property (frame_start |-> frame_params == $past(active_set))
    else $error("params not taken");
  a_params_hold: assert property (!frame_start |-> $stable(frame_params))
    else $error("params moved");
  a_index_next: assert property ($changed(current_index) |->
    current_index == $past(current_index) + `SEQ_IDX_ONE || current_index == `SEQ_FIRST_SET)
    else $error("index jump");
  a_frame_steady: assert property (frame_start ##1 !frame_done |-> $stable(current_index))
    else $error("index moved in frame");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not quiet");
  c_frame: cover property (frame_start);
  c_wrap: cover property ($changed(current_index) && current_index == `SEQ_FIRST_SET);
  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind param_set_sequencer param_set_sequencer_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_done(frame_done),
  .waiting_for_trigger(waiting_for_trigger), .frame_start(frame_start),
  .frame_params(frame_params), .active_set(active_set), .current_index(current_index));

// >>> param_set_sequencer_tb.sv
/* Self-checking bench of the sequencer.
   Assumes design files and frame_source_model compiled first. */
`timescale 1ns/10ps
module param_set_sequencer_tb;
  logic ref_clk, rstn, reg_wr, reg_rd, shoot, rude, waiting_for_trigger;
  logic frame_start, frame_done, frame_trig_pin;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, frame_params, active_set;
  logic [5:0] current_index, idx;
  int err_total, tests_run, cyc, starts;
  // Command nibble beside the index it should give
  logic [7:0] rows [8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h10, 8'h11, 8'h20};
  param_set_sequencer u_param_set_sequencer (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_trig_pin(frame_trig_pin), .frame_done(frame_done),
    .waiting_for_trigger(waiting_for_trigger), .frame_start(frame_start),
    .frame_params(frame_params), .active_set(active_set), .current_index(current_index));
  frame_source_model u_frame_source_model (.ref_clk(ref_clk), .rstn(rstn), .shoot(shoot),
    .rude(rude), .waiting_for_trigger(waiting_for_trigger), .frame_start(frame_start),
    .frame_trig_pin(frame_trig_pin), .frame_done(frame_done));
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (frame_start === 1'b1) starts++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk) begin
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge ref_clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk) begin
      reg_rd <= 1;
      reg_addr <= a;
    end
    @(posedge ref_clk) reg_rd <= 0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  // Waits for frame_start (0) or frame_done (1); the timeout bounds it
  task automatic w(input bit d);
    do begin
      @(posedge ref_clk);
      #1;
    end while ((d ? frame_done : frame_start) !== 1'b1);
  endtask
  task automatic shot();
    @(posedge ref_clk) shoot <= 1;
    w(0);
    @(posedge ref_clk) shoot <= 0;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, shoot, rude, reg_addr, reg_wdata} = '0;
    {err_total, tests_run, cyc, starts} = '0;
    tick(8);
    rstn <= 1;
    #1 chk("waiting", {31'h0, waiting_for_trigger}, 32'h1);
    rd(4'h1, 32'h40);
    rd(4'hF, 32'h0);
    wr(4'h1, 32'h6);
    for (int i = 0; i < 6; i++) begin
      wr(4'h2, i);
      wr(4'h3, 32'hA0 + i);
    end
    wr(4'h4, 32'h5A5A);
    wr(4'h0, 32'h1);
    tick(8);
    chk("active", active_set, 32'hA0);
    idx = 0;
    foreach (rows[r]) begin
      shot();
      chk("params", frame_params, 32'hA0 + idx);
      wr(4'h6, {28'h0, rows[r][7:4]});
      chk("held", {26'h0, current_index}, {26'h0, idx});
      shoot <= 1;
      rude <= 1;
      tick(2);
      shoot <= 0;
      rude <= 0;
      w(1);
      shoot <= 1;
      rude <= 1;
      tick(2);
      #1 chk("busy", {31'h0, waiting_for_trigger}, 32'h0);
      shoot <= 0;
      rude <= 0;
      tick(6);
      idx = {2'h0, rows[r][3:0]};
      chk("index", {26'h0, current_index}, {26'h0, idx});
      chk("active", active_set, 32'hA0 + idx);
    end
    chk("starts", 32'(starts), 32'h8);
    shot();
    wr(4'h0, 32'h0);
    chk("frame", active_set, 32'hA0);
    w(1);
    tick(8);
    chk("restore", active_set, 32'h5A5A);
    rstn <= 0;
    tick(2);
    rstn <= 1;
    #1 chk("rst index", {26'h0, current_index}, 32'h0);
    chk("rst waiting", {31'h0, waiting_for_trigger}, 32'h1);
    rd(4'h1, 32'h40);
    end_of_test();
  end
endmodule

// >>> seq_load_if.sv
/*
  Interface carrying a set load request from the sequencer core to the loader.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface seq_load_if;
  logic start;
  logic busy;
  logic done;
  modport core (output start, input busy, input done);
  modport loader (input start, output busy, output done);
endinterface

// >>> seq_load_timer.sv
/*
  Times the copy of one stored set into the active set.
  Assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/10ps
`include "seq_map.svh"
module seq_load_timer #(
  parameter int LOAD_CYCLES = `SEQ_LOAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  seq_load_if.loader lif
);
  logic [`SEQ_CNT_W-1:0] cnt_reg;
  logic [`SEQ_CNT_W-1:0] cnt_next;
  wire last_cycle = (cnt_reg == `SEQ_CNT_ONE);
  assign cnt_next = lif.start ? LOAD_CYCLES[`SEQ_CNT_W-1:0] :
                    (cnt_reg != `SEQ_CNT_ZERO) ? cnt_reg - `SEQ_CNT_ONE : cnt_reg;
  assign lif.busy = (cnt_reg != `SEQ_CNT_ZERO);
  assign lif.done = last_cycle;
  always_ff @(posedge ref_clk) begin
    if (!rstn) cnt_reg <= `SEQ_CNT_ZERO;
    else cnt_reg <= cnt_next;
  end
endmodule

// >>> seq_map.svh
/*
  Constants of the parameter set sequencer: set counts, widths, offsets, timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define SEQ_MAX_SETS 64
`define SEQ_IDX_W 6
`define SEQ_PARAM_W 32
`define SEQ_FIRST_SET 6'h00
`define SEQ_LOAD_CYCLES 4
`define SEQ_CNT_W 3
`define SEQ_CNT_ZERO 3'h0
`define SEQ_CNT_ONE 3'h1
`define SEQ_IDX_ONE 6'h01
`define SEQ_REG_CTRL 4'h0
`define SEQ_REG_COUNT 4'h1
`define SEQ_REG_SEL 4'h2
`define SEQ_REG_DATA 4'h3
`define SEQ_REG_ACTIVE 4'h4
`define SEQ_REG_STATUS 4'h5
`define SEQ_REG_CMD 4'h6
`define SEQ_BIT_ON 0
`define SEQ_BIT_STEP 0
`define SEQ_BIT_REWIND 1
`define SEQ_ADDR_W 4
`endif

// >>> seq_pkg.sv
/*
  Types shared by the sequencer modules.
  Assumes seq_map.svh is on the include path.
*/
`include "seq_map.svh"
package seq_pkg;
  typedef logic [`SEQ_IDX_W-1:0] idx_t;
  typedef logic [`SEQ_PARAM_W-1:0] param_t;
  typedef enum logic [2:0] {st_idle, st_load, st_wait, st_frame, st_drain} seq_state_e;
endpackage
